//--- common/apc_mem_if.sv
// Port bundle of one small configuration memory.
// Assumes one writer side and one reader side per memory.
`timescale 1ns/1ps
interface apc_mem_if;
    logic       we;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic [7:0] raddr;
    logic [7:0] rdata;

    modport wr  (output we, output waddr, output wdata);
    modport rd  (output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

//--- common/apc_pkg.sv
// Types shared by the control slice modules.
// Assumes the register header is included where offsets are needed.
package apc_pkg;

    typedef enum logic [1:0] {
        APC_PAGE_MASTER,
        APC_PAGE_ADC,
        APC_PAGE_MAIN,
        APC_PAGE_NONE
    } apc_page_t;

    typedef enum logic {
        APC_CMT_IDLE,
        APC_CMT_COPY
    } apc_commit_state_t;

endpackage

//--- common/apc_regs.svh
// Register offsets, field positions and reset values of the control slice.
// Assumes an 8-bit register address qualified by a page select.
// Behaviour
// - Reference-pulse ignore bit set makes the device disregard the external pulse.
// - Bit 1 of sync control enables higher common-mode range on pulse input.
// - Manual enable drives internal reference pulse from the register level bit.
// - Power-down enable powers down exactly the blocks in the selected mask.
// - Route bit outputs channel B fast over-range flag; host writes bit 5 one.
// - One eight-bit threshold sets fast over-range for both channels.
// - Main-digital-page writes stay pending until the commit bit completes a pulse.
// - Mask select bit chooses first mask at zero, second mask at one.
// - First mask from 20h and 21h, second mask from 23h and 24h.
`ifndef APC_REGS_SVH
`define APC_REGS_SVH

`define APC_ADDR_COMMIT      8'h00
`define APC_ADDR_MASK1_LO    8'h20
`define APC_ADDR_MASK1_HI    8'h21
`define APC_ADDR_MASK2_LO    8'h23
`define APC_ADDR_MASK2_HI    8'h24
`define APC_ADDR_PWR_CTRL    8'h26
`define APC_ADDR_PERF_LO     8'h39
`define APC_ADDR_PERF_MID    8'h3A
`define APC_ADDR_SYNC        8'h53
`define APC_ADDR_MANUAL      8'h54
`define APC_ADDR_PDN_EN      8'h55
`define APC_ADDR_PERF_HI     8'h56
`define APC_ADDR_OVR_ROUTE   8'h59
`define APC_ADDR_OVR_THRESH  8'h5F

`define APC_BIT_COMMIT       0
`define APC_BIT_MASK_SEL     5
`define APC_BIT_PERF_LO_MSB  7
`define APC_BIT_PERF_LO_LSB  6
`define APC_BIT_PERF_MID     6
`define APC_BIT_REF_IGNORE   6
`define APC_BIT_REF_HIGH_CM  1
`define APC_BIT_REF_LEVEL    0
`define APC_BIT_MANUAL_EN    7
`define APC_BIT_PDN_EN       4
`define APC_BIT_PERF_HI      2
`define APC_BIT_OVR_ROUTE    7
`define APC_BIT_OVR_ALWAYS1  5

`define APC_RST_BYTE         8'h00
`define APC_RST_BIT          1'b0
`define APC_RST_THRESH       8'h00
`define APC_LAST_INDEX       8'hFF

`endif

//--- logic/apc_commit.sv
// Commit sequencer: copies staged main-page settings into the active copy.
// Assumes the commit level comes from a register and the memories read in one cycle.
`timescale 1ns/1ps
module apc_commit
    import apc_pkg::*;
(
    input  wire logic sys_clk_i,
    input  wire logic reset_n_i,
    input  wire logic commit_level_i,
    output logic      busy_o,
    apc_mem_if.rd     staged,
    apc_mem_if.wr     active
);
`include "apc_regs.svh"

    apc_commit_state_t state;
    logic              level_q;
    logic              request;
    logic [7:0]        index;
    logic [7:0]        index_q;
    logic              valid_q;
    logic              pulse_done;

    assign pulse_done = level_q && !commit_level_i;

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            level_q <= `APC_RST_BIT;
        end else begin
            level_q <= commit_level_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            request <= 1'b0;
        end else if (pulse_done) begin
            request <= 1'b1;
        end else if (state == APC_CMT_IDLE) begin
            request <= 1'b0;
        end
    end

    // Copy walk over all entries
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            state <= APC_CMT_IDLE;
            index <= 8'h00;
        end else begin
            case (state)
                APC_CMT_IDLE: begin
                    index <= 8'h00;
                    if (request) begin
                        state <= APC_CMT_COPY;
                    end
                end
                APC_CMT_COPY: begin
                    index <= index + 8'h01;
                    if (index == `APC_LAST_INDEX) begin
                        state <= APC_CMT_IDLE;
                    end
                end
                default: state <= APC_CMT_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            valid_q <= 1'b0;
            index_q <= 8'h00;
        end else begin
            valid_q <= (state == APC_CMT_COPY);
            index_q <= index;
        end
    end

    assign staged.raddr = index;
    assign active.we    = valid_q;
    assign active.waddr = index_q;
    assign active.wdata = staged.rdata;
    assign busy_o       = (state == APC_CMT_COPY) || valid_q || request;

endmodule

//--- logic/apc_mem.sv
// 256 by 8 configuration memory with registered read data.
// Assumes a single write port and a single read port on one clock.
`timescale 1ns/1ps
module apc_mem
    import apc_pkg::*;
(
    input  wire logic sys_clk_i,
    input  wire logic reset_n_i,
    apc_mem_if.mem    port
);
`include "apc_regs.svh"

    logic [7:0] store [256];

    // Write port
    always_ff @(posedge sys_clk_i) begin
        if (port.we) begin
            store[port.waddr] <= port.wdata;
        end
    end

    // Registered read
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            port.rdata <= `APC_RST_BYTE;
        end else begin
            port.rdata <= store[port.raddr];
        end
    end

endmodule

//--- logic/apc_sync_power_ctrl.sv
// Reference-pulse, power-down, performance and over-range control registers.
// Assumes a serial port front end delivers decoded register strobes.
`timescale 1ns/1ps
module apc_sync_power_ctrl
    import apc_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire apc_page_t  reg_page_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       ext_ref_pulse_i,
    input  wire logic       readback_data_i,
    input  wire logic [7:0] chan_a_level_i,
    input  wire logic [7:0] chan_b_level_i,
    input  wire logic [7:0] mdp_cfg_addr_i,
    output logic [7:0]      reg_rdata_o,
    output logic            reg_rvalid_o,
    output logic            ref_pulse_o,
    output logic            ref_pulse_high_cm_enable_o,
    output logic [15:0]     powerdown_blocks_o,
    output logic [3:0]      performance_setting_o,
    output logic [7:0]      fast_overrange_threshold_o,
    output logic            fast_overrange_flag_a_o,
    output logic            fast_overrange_flag_b_o,
    output logic            serial_readback_pin_o,
    output logic [7:0]      mdp_cfg_data_o,
    output logic            commit_busy_o
);
`include "apc_regs.svh"

    function automatic logic hit(input apc_page_t pg, input logic [7:0] addr,
                                 input apc_page_t want_pg, input logic [7:0] want_addr);
        hit = (pg == want_pg) && (addr == want_addr);
    endfunction

    function automatic logic over(input logic [7:0] level, input logic [7:0] thresh);
        over = (level >= thresh);
    endfunction

    apc_mem_if staged_if ();
    apc_mem_if active_if ();

    logic       commit_level;
    logic       commit_busy;
    logic [7:0] mask1_lo;
    logic [7:0] mask1_hi;
    logic [7:0] mask2_lo;
    logic [7:0] mask2_hi;
    logic       powerdown_mask_select;
    logic [1:0] perf_lo;
    logic       perf_mid;
    logic       perf_hi;
    logic       ref_pulse_ignore;
    logic       ref_pulse_high_cm_enable;
    logic       ref_pulse_manual_level;
    logic       ref_pulse_manual_enable;
    logic       register_powerdown_enable;
    logic       chan_b_fast_overrange_route;
    logic       route_always_one;
    logic [7:0] fast_overrange_threshold;
    logic [7:0] next_rdata;
    logic       fast_overrange_flag_b;

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            commit_level <= `APC_RST_BIT;
        end else if (reg_wr_i && hit(reg_page_i, reg_addr_i, APC_PAGE_MAIN, `APC_ADDR_COMMIT)) begin
            commit_level <= reg_wdata_i[`APC_BIT_COMMIT];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            staged_if.we    <= 1'b0;
            staged_if.waddr <= 8'h00;
            staged_if.wdata <= 8'h00;
        end else begin
            staged_if.we    <= reg_wr_i && (reg_page_i == APC_PAGE_MAIN)
                               && (reg_addr_i != `APC_ADDR_COMMIT);
            staged_if.waddr <= reg_addr_i;
            staged_if.wdata <= reg_wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            mask1_lo <= `APC_RST_BYTE;
            mask1_hi <= `APC_RST_BYTE;
            mask2_lo <= `APC_RST_BYTE;
            mask2_hi <= `APC_RST_BYTE;
        end else if (reg_wr_i) begin
            if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_MASK1_LO)) begin
                mask1_lo <= reg_wdata_i;
            end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_MASK1_HI)) begin
                mask1_hi <= reg_wdata_i;
            end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_MASK2_LO)) begin
                mask2_lo <= reg_wdata_i;
            end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_MASK2_HI)) begin
                mask2_hi <= reg_wdata_i;
            end
        end
    end

    // Master page control bits
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            powerdown_mask_select       <= `APC_RST_BIT;
            perf_lo                     <= 2'h0;
            perf_mid                    <= `APC_RST_BIT;
            perf_hi                     <= `APC_RST_BIT;
            ref_pulse_ignore            <= `APC_RST_BIT;
            ref_pulse_high_cm_enable    <= `APC_RST_BIT;
            ref_pulse_manual_level      <= `APC_RST_BIT;
            ref_pulse_manual_enable     <= `APC_RST_BIT;
            register_powerdown_enable   <= `APC_RST_BIT;
            chan_b_fast_overrange_route <= `APC_RST_BIT;
            route_always_one            <= `APC_RST_BIT;
        end else if (reg_wr_i) begin
            if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_PWR_CTRL)) begin
                powerdown_mask_select <= reg_wdata_i[`APC_BIT_MASK_SEL];
            end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_PERF_LO)) begin
                perf_lo <= reg_wdata_i[`APC_BIT_PERF_LO_MSB:`APC_BIT_PERF_LO_LSB];
            end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_PERF_MID)) begin
                perf_mid <= reg_wdata_i[`APC_BIT_PERF_MID];
            end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_PERF_HI)) begin
                perf_hi <= reg_wdata_i[`APC_BIT_PERF_HI];
            end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_SYNC)) begin
                ref_pulse_ignore         <= reg_wdata_i[`APC_BIT_REF_IGNORE];
                ref_pulse_high_cm_enable <= reg_wdata_i[`APC_BIT_REF_HIGH_CM];
                ref_pulse_manual_level   <= reg_wdata_i[`APC_BIT_REF_LEVEL];
            end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_MANUAL)) begin
                ref_pulse_manual_enable <= reg_wdata_i[`APC_BIT_MANUAL_EN];
            end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_PDN_EN)) begin
                register_powerdown_enable <= reg_wdata_i[`APC_BIT_PDN_EN];
            end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_OVR_ROUTE)) begin
                chan_b_fast_overrange_route <= reg_wdata_i[`APC_BIT_OVR_ROUTE];
                route_always_one            <= reg_wdata_i[`APC_BIT_OVR_ALWAYS1];
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            fast_overrange_threshold <= `APC_RST_THRESH;
        end else if (reg_wr_i
                     && hit(reg_page_i, reg_addr_i, APC_PAGE_ADC, `APC_ADDR_OVR_THRESH)) begin
            fast_overrange_threshold <= reg_wdata_i;
        end
    end

    // Read mux, write-only bits read zero
    always_comb begin
        next_rdata = 8'h00;
        if (hit(reg_page_i, reg_addr_i, APC_PAGE_MAIN, `APC_ADDR_COMMIT)) begin
            next_rdata[`APC_BIT_COMMIT] = commit_level;
        end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_MASK1_LO)) begin
            next_rdata = mask1_lo;
        end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_MASK1_HI)) begin
            next_rdata = mask1_hi;
        end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_MASK2_LO)) begin
            next_rdata = mask2_lo;
        end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_MASK2_HI)) begin
            next_rdata = mask2_hi;
        end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_PWR_CTRL)) begin
            next_rdata[`APC_BIT_MASK_SEL] = powerdown_mask_select;
        end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_PERF_LO)) begin
            next_rdata[`APC_BIT_PERF_LO_MSB:`APC_BIT_PERF_LO_LSB] = perf_lo;
        end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_PERF_MID)) begin
            next_rdata[`APC_BIT_PERF_MID] = perf_mid;
        end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_SYNC)) begin
            next_rdata[`APC_BIT_REF_IGNORE]  = ref_pulse_ignore;
            next_rdata[`APC_BIT_REF_HIGH_CM] = ref_pulse_high_cm_enable;
            next_rdata[`APC_BIT_REF_LEVEL]   = ref_pulse_manual_level;
        end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_MANUAL)) begin
            next_rdata[`APC_BIT_MANUAL_EN] = ref_pulse_manual_enable;
        end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_PDN_EN)) begin
            next_rdata[`APC_BIT_PDN_EN] = register_powerdown_enable;
        end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_MASTER, `APC_ADDR_OVR_ROUTE)) begin
            next_rdata[`APC_BIT_OVR_ALWAYS1] = route_always_one;
        end else if (hit(reg_page_i, reg_addr_i, APC_PAGE_ADC, `APC_ADDR_OVR_THRESH)) begin
            next_rdata = fast_overrange_threshold;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rdata_o  <= reg_rd_i ? next_rdata : 8'h00;
            reg_rvalid_o <= reg_rd_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            ref_pulse_o <= 1'b0;
        end else if (ref_pulse_manual_enable) begin
            ref_pulse_o <= ref_pulse_manual_level;
        end else begin
            ref_pulse_o <= ext_ref_pulse_i && !ref_pulse_ignore;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            ref_pulse_high_cm_enable_o <= 1'b0;
        end else begin
            ref_pulse_high_cm_enable_o <= ref_pulse_high_cm_enable;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            powerdown_blocks_o <= 16'h0000;
        end else if (!register_powerdown_enable) begin
            powerdown_blocks_o <= 16'h0000;
        end else if (powerdown_mask_select) begin
            powerdown_blocks_o <= {mask2_hi, mask2_lo};
        end else begin
            powerdown_blocks_o <= {mask1_hi, mask1_lo};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            performance_setting_o <= 4'h0;
        end else begin
            performance_setting_o <= {perf_hi, perf_mid, perf_lo};
        end
    end

    assign fast_overrange_flag_b = over(chan_b_level_i, fast_overrange_threshold);

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            fast_overrange_threshold_o <= `APC_RST_THRESH;
            fast_overrange_flag_a_o    <= 1'b0;
            fast_overrange_flag_b_o    <= 1'b0;
        end else begin
            fast_overrange_threshold_o <= fast_overrange_threshold;
            fast_overrange_flag_a_o    <= over(chan_a_level_i, fast_overrange_threshold);
            fast_overrange_flag_b_o    <= fast_overrange_flag_b;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            serial_readback_pin_o <= 1'b0;
        end else if (chan_b_fast_overrange_route) begin
            serial_readback_pin_o <= fast_overrange_flag_b;
        end else begin
            serial_readback_pin_o <= readback_data_i;
        end
    end

    assign active_if.raddr = mdp_cfg_addr_i;
    assign mdp_cfg_data_o  = active_if.rdata;

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            commit_busy_o <= 1'b0;
        end else begin
            commit_busy_o <= commit_busy;
        end
    end

    apc_mem u_staged (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .port      (staged_if.mem)
    );

    apc_mem u_active (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .port      (active_if.mem)
    );

    apc_commit u_commit (
        .sys_clk_i      (sys_clk_i),
        .reset_n_i      (reset_n_i),
        .commit_level_i (commit_level),
        .busy_o         (commit_busy),
        .staged         (staged_if.rd),
        .active         (active_if.wr)
    );

endmodule

//--- test/adc_sync_power_control_regs_tb.sv
// Self-checking bench of the control slice.
// Assumes the host model and the bound port checker.
`timescale 1ns/1ps
module adc_sync_power_control_regs_tb;
    import apc_pkg::*;
    logic        sys_clk_i, reset_n_i, reg_wr_i, reg_rd_i, reg_rvalid_o, ref_pulse_o, hcm, busy;
    logic        ext_ref_pulse_i, readback_data_i, flag_a, flag_b, pin;
    apc_page_t   reg_page_i;
    logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, chan_a, chan_b, mdp_addr, thr_o, mdp_data;
    logic [15:0] pdn_o;
    logic [3:0]  perf_o;
    logic [8:0]  q;
    int          bad_count, checked, thr, m1, m2, d, e;
    apc_sync_power_ctrl dut (.*, .chan_a_level_i(chan_a), .chan_b_level_i(chan_b),
        .mdp_cfg_addr_i(mdp_addr), .ref_pulse_high_cm_enable_o(hcm), .powerdown_blocks_o(pdn_o),
        .performance_setting_o(perf_o), .fast_overrange_threshold_o(thr_o),
        .fast_overrange_flag_a_o(flag_a), .fast_overrange_flag_b_o(flag_b),
        .serial_readback_pin_o(pin), .mdp_cfg_data_o(mdp_data), .commit_busy_o(busy));
    apc_host_model host (.sys_clk_i, .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o),
        .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_page_o(reg_page_i),
        .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
    initial sys_clk_i = 1'h0;
    always #50 sys_clk_i = ~sys_clk_i;
    task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rd(input apc_page_t p, input logic [7:0] a, input logic [7:0] exp);
        host.rd(p, a, q);
        chk_out({7'h00, q}, {8'h01, exp});
    endtask
    task automatic settle();
        repeat (4) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wait_busy(input logic lvl);
        for (int n = 0; n < 700 && busy !== lvl; n++) @(posedge sys_clk_i) #1;
        chk_out({15'h0000, busy}, {15'h0000, lvl});
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        bad_count++;
        summarize();
    end
    initial begin
        {reset_n_i, ext_ref_pulse_i, readback_data_i, chan_a, chan_b, mdp_addr} = '0;
        repeat (16) @(posedge sys_clk_i);
        #1;
        reset_n_i = 1'h1;
        void'($urandom(80));
        for (int i = 0; i < 7; i++) chk_rd(APC_PAGE_MASTER, 8'h53 + 8'(i), 8'h00);
        chk_rd(APC_PAGE_ADC, 8'h5F, 8'h00);
        chk_rd(APC_PAGE_MAIN, 8'h00, 8'h00);
        for (int i = 0; i < 4; i++) begin
            d = $urandom % 16;
            host.perf(d[3:0]);
            settle();
            chk_out({12'h000, perf_o}, 16'(d));
            chk_rd(APC_PAGE_MASTER, 8'h39, {d[1:0], 6'h00});
            chk_rd(APC_PAGE_MASTER, 8'h56, 8'h00);
        end
        for (int i = 0; i < 16; i++) begin
            d = $urandom % 2;
            ext_ref_pulse_i = d[0];
            host.wr(APC_PAGE_MASTER, 8'h54, {i[1], 7'h00}, 1'h1);
            host.wr(APC_PAGE_MASTER, 8'h53, {1'h0, i[0], 4'h0, i[3], i[2]});
            settle();
            e = i[1] ? i[2] : (d & !i[0]);
            chk_out({14'h0000, hcm, ref_pulse_o}, {14'h0000, i[3], 1'(e)});
            chk_rd(APC_PAGE_MASTER, 8'h53, {1'h0, i[0], 4'h0, i[3], i[2]});
        end
        m1 = $urandom;
        m2 = $urandom;
        host.wr(APC_PAGE_MASTER, 8'h20, m1[7:0], 1'h1);
        host.wr(APC_PAGE_MASTER, 8'h21, m1[15:8], 1'h1);
        host.wr(APC_PAGE_MASTER, 8'h23, m2[7:0], 1'h1);
        host.wr(APC_PAGE_MASTER, 8'h24, m2[15:8]);
        for (int i = 0; i < 4; i++) begin
            host.wr(APC_PAGE_MASTER, 8'h26, {2'h0, i[0], 5'h00}, 1'h1);
            host.wr(APC_PAGE_MASTER, 8'h55, {3'h0, i[1], 4'h0});
            settle();
            e = !i[1] ? 0 : (i[0] ? m2 : m1);
            chk_out(pdn_o, 16'(e));
        end
        host.wr(APC_PAGE_MASTER, 8'h4F, 8'hFF);
        chk_rd(APC_PAGE_MASTER, 8'h4F, 8'h00);
        chk_rd(APC_PAGE_NONE, 8'h55, 8'h00);
        thr = $urandom % 256;
        host.wr(APC_PAGE_ADC, 8'h5F, thr[7:0], 1'h1);
        for (int i = 0; i < 8; i++) begin
            chan_a = (i == 0) ? thr[7:0] : 8'($urandom);
            chan_b = (i == 1) ? thr[7:0] - 8'h01 : 8'($urandom);
            readback_data_i = i[0];
            host.wr(APC_PAGE_MASTER, 8'h59, {i[1], 7'h00});
            settle();
            e = i[1] ? (chan_b >= thr) : i[0];
            chk_out({5'h00, flag_a, flag_b, pin, thr_o},
                    {5'h00, chan_a >= thr, chan_b >= thr, 1'(e), 8'(thr)});
        end
        chk_rd(APC_PAGE_MASTER, 8'h59, 8'h20);
        mdp_addr = 8'h41;
        d = $urandom % 256;
        for (int k = 0; k < 2; k++) begin
            host.wr(APC_PAGE_MAIN, 8'h41, d[7:0], 1'h1);
            host.commit();
            wait_busy(1'h1);
            wait_busy(1'h0);
            settle();
            chk_out({8'h00, mdp_data}, {8'h00, d[7:0]});
            host.wr(APC_PAGE_MAIN, 8'h41, ~d[7:0]);
            settle();
            chk_out({8'h00, mdp_data}, {8'h00, d[7:0]});
            d = ~d;
        end
        summarize();
    end
endmodule

//--- test/apc_ctrl_monitor.sv
// Port checker of the control slice.
// Assumes binding to apc_sync_power_ctrl.
`timescale 1ns/1ps
module apc_ctrl_monitor
    import apc_pkg::*;
(
    input logic        sys_clk_i,
    input logic        reset_n_i,
    input logic        reg_wr_i,
    input logic        reg_rd_i,
    input apc_page_t   reg_page_i,
    input logic [7:0]  reg_addr_i,
    input logic [7:0]  reg_wdata_i,
    input logic        readback_data_i,
    input logic [7:0]  chan_a_level_i,
    input logic [7:0]  chan_b_level_i,
    input logic [7:0]  reg_rdata_o,
    input logic        reg_rvalid_o,
    input logic        ref_pulse_o,
    input logic [15:0] powerdown_blocks_o,
    input logic [3:0]  performance_setting_o,
    input logic [7:0]  fast_overrange_threshold_o,
    input logic        fast_overrange_flag_a_o,
    input logic        fast_overrange_flag_b_o,
    input logic        serial_readback_pin_o,
    input logic        commit_busy_o
);
    logic [9:0] busy_cnt;
    logic       ready;
    always_ff @(posedge sys_clk_i) begin
        ready <= reset_n_i;
        if (!reset_n_i || !commit_busy_o) begin
            busy_cnt <= 10'h000;
        end else begin
            busy_cnt <= busy_cnt + 10'h001;
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_wr(apc_page_t p, logic [7:0] a);
        reg_wr_i && reg_page_i == p && reg_addr_i == a;
    endsequence
    sequence s_pulse;
        s_wr(APC_PAGE_MAIN, 8'h00) ##0 reg_wdata_i[0] ##1 s_wr(APC_PAGE_MAIN, 8'h00) ##0 !reg_wdata_i[0];
    endsequence
    a_commit_start: assert property (s_pulse |-> ##3 commit_busy_o)
        else $error("commit copy did not start");
    a_busy_bound: assert property (commit_busy_o |-> busy_cnt < 10'h258)
        else $error("commit copy runs too long");
    a_thresh_write: assert property (s_wr(APC_PAGE_ADC, 8'h5F) |->
        ##2 fast_overrange_threshold_o == $past(reg_wdata_i, 2)) else $error("threshold not stored");
    a_perf_top: assert property (s_wr(APC_PAGE_MASTER, 8'h56) |->
        ##2 performance_setting_o[3] == $past(reg_wdata_i[2], 2)) else $error("perf bit wrong");
    a_pdn_off: assert property (s_wr(APC_PAGE_MASTER, 8'h55) ##0 !reg_wdata_i[4] |->
        ##2 powerdown_blocks_o == 16'h0000) else $error("blocks down while disabled");
    a_manual_level: assert property (s_wr(APC_PAGE_MASTER, 8'h54) ##0 reg_wdata_i[7]
        ##1 s_wr(APC_PAGE_MASTER, 8'h53) |-> ##2 ref_pulse_o == $past(reg_wdata_i[0], 2))
        else $error("manual pulse level wrong");
    a_read_valid: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered");
    a_read_idle: assert property (!reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == 8'h00)
        else $error("read data without read");
    a_flag_compare: assert property (ready |->
        fast_overrange_flag_a_o == ($past(chan_a_level_i) >= fast_overrange_threshold_o) &&
        fast_overrange_flag_b_o == ($past(chan_b_level_i) >= fast_overrange_threshold_o))
        else $error("over-range flag wrong");
    a_pin_source: assert property (ready |-> serial_readback_pin_o == fast_overrange_flag_b_o ||
        serial_readback_pin_o == $past(readback_data_i)) else $error("readback pin source wrong");
endmodule
bind apc_sync_power_ctrl apc_ctrl_monitor u_mon (.*);

//--- test/apc_host_model.sv
// Configuration host that issues register writes and reads.
// Assumes each call starts 1 ns after a clock edge.
`timescale 1ns/1ps
module apc_host_model
    import apc_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_rvalid_i,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output apc_page_t       reg_page_o,
    output logic [7:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o
);
    initial reg_page_o = APC_PAGE_NONE;
    initial {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = '0;

    task automatic wr(input apc_page_t p, input logic [7:0] a, d, input bit keep = 1'h0);
        reg_wr_o   = 1'h1;
        reg_page_o = p;
        reg_addr_o = a;
        reg_wdata_o = (p == APC_PAGE_MASTER && a == 8'h59) ? (d | 8'h20) : d;
        @(posedge sys_clk_i);
        #1;
        if (!keep) begin
            reg_wr_o = 1'h0;
        end
    endtask

    task automatic rd(input apc_page_t p, input logic [7:0] a, output logic [8:0] q);
        reg_rd_o   = 1'h1;
        reg_page_o = p;
        reg_addr_o = a;
        @(posedge sys_clk_i);
        #1;
        reg_rd_o = 1'h0;
        q        = {reg_rvalid_i, reg_rdata_i};
        @(posedge sys_clk_i);
        #1;
    endtask

    task automatic commit();
        wr(APC_PAGE_MAIN, 8'h00, 8'h01, 1'h1);
        wr(APC_PAGE_MAIN, 8'h00, 8'h00);
    endtask

    task automatic perf(input logic [3:0] v);
        wr(APC_PAGE_MASTER, 8'h39, {v[1:0], 6'h00}, 1'h1);
        wr(APC_PAGE_MASTER, 8'h3A, {1'h0, v[2], 6'h00}, 1'h1);
        wr(APC_PAGE_MASTER, 8'h56, {5'h00, v[3], 2'h0});
    endtask
endmodule
